// ==== design/irq_pkg.sv ====
package irq_pkg;

    // Sources in fixed polling order, index 0 is polled first.
    localparam int NUM_SOURCES = 15;
    localparam int SRC_W       = 4;
    localparam logic [3:0] S_X0   = 4'h0;
    localparam logic [3:0] S_I2C  = 4'h1;
    localparam logic [3:0] S_ADC  = 4'h2;
    localparam logic [3:0] S_T0   = 4'h3;
    localparam logic [3:0] S_CT0  = 4'h4;
    localparam logic [3:0] S_CM0  = 4'h5;
    localparam logic [3:0] S_X1   = 4'h6;
    localparam logic [3:0] S_CT1  = 4'h7;
    localparam logic [3:0] S_CM1  = 4'h8;
    localparam logic [3:0] S_T1   = 4'h9;
    localparam logic [3:0] S_CT2  = 4'ha;
    localparam logic [3:0] S_CM2  = 4'hb;
    localparam logic [3:0] S_UART = 4'hc;
    localparam logic [3:0] S_CT3  = 4'hd;
    localparam logic [3:0] S_T2   = 4'he;

    // Request flag positions.
    localparam int NUM_FLAGS = 17;
    localparam int F_EXTA    = 0;
    localparam int F_EXTB    = 1;
    localparam int F_TMRA    = 2;
    localparam int F_TMRB    = 3;
    localparam int F_CT0     = 4;
    localparam int F_CM0     = 8;
    localparam int F_T2OVF   = 11;
    localparam int F_URX     = 12;
    localparam int F_UTX     = 13;
    localparam int F_I2C     = 14;
    localparam int F_ADC     = 15;
    localparam int F_ONEHZ   = 16;

    // Machine cycle length and vector layout defaults.
    localparam int DIV_W                  = 8;
    localparam int MACHINE_CYCLE_CLKS_DEF = 12;
    localparam logic [15:0] VEC_BASE_DEF  = 16'h0003;
    localparam logic [15:0] VEC_STEP_DEF  = 16'h0008;
    localparam logic [2:0]  SYNC_IDLE     = 3'h7;

    typedef struct packed {
        logic [2:0]            syncA;
        logic [2:0]            syncB;
        logic [3:0][2:0]       capSync;
        logic                  fltA;
        logic                  fltB;
        logic [3:0]            capFlt;
        logic [DIV_W-1:0]      divCnt;
        logic [NUM_FLAGS-1:0]  flags;
        logic [NUM_SOURCES-1:0] sampled;
        logic                  activeHi;
        logic                  activeLo;
        logic                  vectorCall;
        logic                  pcRestore;
        logic [15:0]           vecAddr;
        logic [SRC_W-1:0]      vecIdx;
    } irq_state_t;

endpackage : irq_pkg

// ==== design/two_level_nested_interrupt_unit.sv ====
// Function
// - Fifteen request sources feed the polling logic.
// - Each external input selects level or edge.
// - Vectoring clears external flag only if edge.
// - External inputs are active low.
// - Timer A and B overflow flags set, cleared on vectoring.
// - Seven capture/compare sources, never cleared on vectoring.
// - UART request is receive OR transmit flag.
// - I2C event flag cleared only by software.
// - ADC flag set by scan end, software cannot set.
// - One-hertz tick ORed onto second external source.
// - Software set and clear act like hardware, except software set of ADC.
// - Only six named requests end idle mode.
// - Individual enables plus global enable.
// - One priority bit per source, one is high.
// - High preempts low; high never preempted.
// - Higher level wins, polling order breaks ties.
// - Sample each machine cycle, poll next, call.
// - Withhold call during equal or higher handler.
// - Call only at instruction's final cycle.
// - One instruction after return or register access.
// - Capture pins act as edge-configurable interrupts.
// - Call pushes counter, not status, loads vector.
// - Return clears active level, restores counter.
// - Blocked requests are not remembered between polls.
`timescale 1ns/1ps
`default_nettype none

module two_level_nested_interrupt_unit
    import irq_pkg::*;
#(
    parameter int          MACHINE_CYCLE_CLKS = MACHINE_CYCLE_CLKS_DEF,
    parameter logic [15:0] VEC_BASE           = VEC_BASE_DEF,
    parameter logic [15:0] VEC_STEP           = VEC_STEP_DEF
)
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   extIrqPinA_n,
    input  wire logic                   extIrqPinB_n,
    input  wire logic                   extAEdgeSelect,
    input  wire logic                   extBEdgeSelect,
    input  wire logic [3:0]             capturePin,
    input  wire logic [3:0]             captureIrqRise,
    input  wire logic [3:0]             captureIrqFall,
    input  wire logic                   timerAOverflow,
    input  wire logic                   timerBOverflow,
    input  wire logic [3:0]             t2CaptureEvent,
    input  wire logic [2:0]             t2CompareEvent,
    input  wire logic                   t2Overflow,
    input  wire logic                   uartRxDone,
    input  wire logic                   uartTxDone,
    input  wire logic                   i2cEvent,
    input  wire logic                   adcScanDone,
    input  wire logic                   oneHzTick,
    input  wire logic [NUM_FLAGS-1:0]   swFlagSet,
    input  wire logic [NUM_FLAGS-1:0]   swFlagClear,
    input  wire logic                   globalIrqEnable,
    input  wire logic [NUM_SOURCES-1:0] irqEnable,
    input  wire logic [NUM_SOURCES-1:0] irqLevel,
    input  wire logic                   instrEnd,
    input  wire logic                   irqReturnInstr,
    input  wire logic                   enPrioAccess,
    output logic                        vectorCall,
    output logic [15:0]                 vectorAddr,
    output logic [SRC_W-1:0]            vectorSource,
    output logic                        pcRestore,
    output logic                        activeHigh,
    output logic                        activeLow,
    output logic [NUM_FLAGS-1:0]        requestFlags,
    output logic                        idleWake
);

    if (MACHINE_CYCLE_CLKS < 2 || MACHINE_CYCLE_CLKS > (1 << DIV_W))
    begin : g_cycle_check
        $error("MACHINE_CYCLE_CLKS out of range.");
    end

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MACHINE_CYCLE_CLKS - 1);

    // Map the flags onto the sources in polling order.
    function automatic logic [NUM_SOURCES-1:0] reqFromFlags(input logic [NUM_FLAGS-1:0] f);
        logic [NUM_SOURCES-1:0] r;
        r         = '0;
        r[S_X0]   = f[F_EXTA];
        r[S_I2C]  = f[F_I2C];
        r[S_ADC]  = f[F_ADC];
        r[S_T0]   = f[F_TMRA];
        r[S_CT0]  = f[F_CT0];
        r[S_CM0]  = f[F_CM0];
        r[S_X1]   = f[F_EXTB] | f[F_ONEHZ];
        r[S_CT1]  = f[F_CT0 + 1];
        r[S_CM1]  = f[F_CM0 + 1];
        r[S_T1]   = f[F_TMRB];
        r[S_CT2]  = f[F_CT0 + 2];
        r[S_CM2]  = f[F_CM0 + 2];
        r[S_UART] = f[F_URX] | f[F_UTX];
        r[S_CT3]  = f[F_CT0 + 3];
        r[S_T2]   = f[F_T2OVF];
        return r;
    endfunction : reqFromFlags

    // Lowest set index wins, which is the fixed polling order.
    function automatic logic [SRC_W-1:0] firstSet(input logic [NUM_SOURCES-1:0] v);
        logic [SRC_W-1:0] idx;
        idx = '0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--)
        begin
            if (v[i])
                idx = SRC_W'(i);
        end
        return idx;
    endfunction : firstSet

    irq_state_t             s;
    irq_state_t             n;
    logic                   samplePhase;
    logic                   fallA;
    logic                   fallB;
    logic [3:0]             capEdge;
    logic [NUM_FLAGS-1:0]   setV;
    logic [NUM_FLAGS-1:0]   clrV;
    logic [NUM_SOURCES-1:0] pend;
    logic [NUM_SOURCES-1:0] hiPend;
    logic [NUM_SOURCES-1:0] cand;
    logic                   useHi;
    logic                   blocked;
    logic                   issue;
    logic [SRC_W-1:0]       winIdx;

    always_comb
    begin
        n = s;
        // Three-stage pin synchronisers; a change counts once stages two and three agree.
        n.syncA = {s.syncA[1:0], extIrqPinA_n};
        n.syncB = {s.syncB[1:0], extIrqPinB_n};
        if (s.syncA[1] == s.syncA[2])
            n.fltA = s.syncA[2];
        if (s.syncB[1] == s.syncB[2])
            n.fltB = s.syncB[2];
        fallA = s.fltA & ~n.fltA;
        fallB = s.fltB & ~n.fltB;
        for (int i = 0; i < 4; i++)
        begin
            n.capSync[i] = {s.capSync[i][1:0], capturePin[i]};
            if (s.capSync[i][1] == s.capSync[i][2])
                n.capFlt[i] = s.capSync[i][2];
            capEdge[i] = (captureIrqRise[i] & ~s.capFlt[i] & n.capFlt[i])
                       | (captureIrqFall[i] & s.capFlt[i] & ~n.capFlt[i]);
        end

        // Machine cycle divider; the last clock of each machine cycle is the sample phase.
        samplePhase = (s.divCnt == DIV_LAST);
        n.divCnt    = samplePhase ? '0 : s.divCnt + 1'b1;

        // Priority resolution over the current samples only.
        pend    = s.sampled & irqEnable & {NUM_SOURCES{globalIrqEnable}};
        hiPend  = pend & irqLevel;
        useHi   = |hiPend;
        cand    = useHi ? hiPend : (pend & ~irqLevel);
        winIdx  = firstSet(cand);
        blocked = s.activeHi | (~useHi & s.activeLo)
                | ~instrEnd
                | irqReturnInstr | enPrioAccess;
        issue   = (|cand) & ~blocked;

        // Hardware and software flag updates; a set always wins over a clear.
        setV               = swFlagSet;
        setV[F_ADC]        = adcScanDone;
        setV[F_EXTA]      |= extAEdgeSelect ? fallA : ~s.fltA;
        setV[F_EXTB]      |= extBEdgeSelect ? fallB : ~s.fltB;
        setV[F_TMRA]      |= timerAOverflow;
        setV[F_TMRB]      |= timerBOverflow;
        setV[F_CT0 +: 4]  |= t2CaptureEvent | capEdge;
        setV[F_CM0 +: 3]  |= t2CompareEvent;
        setV[F_T2OVF]     |= t2Overflow;
        setV[F_URX]       |= uartRxDone;
        setV[F_UTX]       |= uartTxDone;
        setV[F_I2C]       |= i2cEvent;
        setV[F_ONEHZ]     |= oneHzTick;
        clrV               = swFlagClear;
        clrV[F_EXTA]      |= ~extAEdgeSelect & s.fltA;
        clrV[F_EXTB]      |= ~extBEdgeSelect & s.fltB;
        if (issue)
        begin
            clrV[F_TMRA] |= (winIdx == S_T0);
            clrV[F_TMRB] |= (winIdx == S_T1);
            clrV[F_EXTA] |= (winIdx == S_X0) & extAEdgeSelect;
            clrV[F_EXTB] |= (winIdx == S_X1) & extBEdgeSelect;
        end
        n.flags = (s.flags & ~clrV) | setV;

        // Sampled once per machine cycle; a serviced sample is dropped outside the sample phase.
        if (samplePhase)
            n.sampled = reqFromFlags(s.flags);
        else if (issue)
            n.sampled[winIdx] = 1'b0;

        n.vectorCall = issue;
        n.pcRestore  = instrEnd & irqReturnInstr;
        if (issue)
        begin
            n.vecIdx  = winIdx;
            n.vecAddr = VEC_BASE + 16'(winIdx) * VEC_STEP;
            if (useHi)
                n.activeHi = 1'b1;
            else
                n.activeLo = 1'b1;
        end
        else if (instrEnd & irqReturnInstr)
        begin
            if (s.activeHi)
                n.activeHi = 1'b0;
            else
                n.activeLo = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s         <= '0;
            s.syncA   <= SYNC_IDLE;
            s.syncB   <= SYNC_IDLE;
            s.capSync <= '0;
            s.fltA    <= 1'b1;
            s.fltB    <= 1'b1;
        end
        else
            s <= n;
    end

    assign vectorCall   = s.vectorCall;
    assign vectorAddr   = s.vecAddr;
    assign vectorSource = s.vecIdx;
    assign pcRestore    = s.pcRestore;
    assign activeHigh   = s.activeHi;
    assign activeLow    = s.activeLo;
    assign requestFlags = s.flags;
    assign idleWake     = globalIrqEnable & |(reqFromFlags(s.flags) & irqEnable & ~15'h6db4);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_call_at_end:    assert property (vectorCall |-> $past(instrEnd) && !$past(irqReturnInstr))
        else $error("Call outside final instruction cycle.");
    a_access_blocks:  assert property ($past(enPrioAccess) |-> !vectorCall)
        else $error("Call during enable or priority access.");
    a_high_no_preempt: assert property ($past(s.activeHi) |-> !vectorCall)
        else $error("High handler was preempted.");
    a_low_equal_block: assert property (vectorCall && $past(s.activeLo) |-> activeHigh && irqLevel[vectorSource])
        else $error("Low handler preempted by low request.");
    a_global_gate:    assert property (!$past(globalIrqEnable) |-> !vectorCall)
        else $error("Call while globally disabled.");
    a_timer_clear:    assert property (vectorCall && vectorSource == S_T0 && !$past(timerAOverflow)
                                       && !$past(swFlagSet[F_TMRA]) |-> !requestFlags[F_TMRA])
        else $error("Timer flag not cleared on vectoring.");
    a_uart_kept:      assert property ($past(s.flags[F_URX]) && !$past(swFlagClear[F_URX]) |-> requestFlags[F_URX])
        else $error("UART receive flag lost without software clear.");
    a_adc_no_swset:   assert property (!$past(s.flags[F_ADC]) && !$past(adcScanDone) |-> !requestFlags[F_ADC])
        else $error("ADC flag set without scan end.");
    a_ret_clears:     assert property (instrEnd && irqReturnInstr && s.activeHi |=> !activeHigh && pcRestore)
        else $error("Return did not clear active high level.");
    a_vec_addr:       assert property (vectorCall |-> vectorAddr == VEC_BASE + 16'(vectorSource) * VEC_STEP)
        else $error("Vector address does not match source.");
    a_sample_fresh:   assert property (samplePhase |=> s.sampled == reqFromFlags($past(s.flags)))
        else $error("Samples not refreshed at sample phase.");
    a_level_ext:      assert property (!extAEdgeSelect && !s.fltA |=> requestFlags[F_EXTA])
        else $error("Level external request not flagged.");
    a_i2c_kept:       assert property ($past(s.flags[F_I2C]) && !$past(swFlagClear[F_I2C])
                                       |-> requestFlags[F_I2C])
        else $error("I2C event flag lost without software clear.");
    a_t2_kept:        assert property ((($past(s.flags[F_CT0 +: 8]) & ~$past(swFlagClear[F_CT0 +: 8]))
                                       & ~requestFlags[F_CT0 +: 8]) == 8'h00)
        else $error("Capture or compare flag lost without software clear.");
    a_edge_clear_a:   assert property (vectorCall && vectorSource == S_X0 && $past(extAEdgeSelect)
                                       && !$past(swFlagSet[F_EXTA]) && !$past(fallA) |-> !requestFlags[F_EXTA])
        else $error("Edge external flag A not cleared on vectoring.");
    a_edge_clear_b:   assert property (vectorCall && vectorSource == S_X1 && $past(extBEdgeSelect)
                                       && !$past(swFlagSet[F_EXTB]) && !$past(fallB) |-> !requestFlags[F_EXTB])
        else $error("Edge external flag B not cleared on vectoring.");
    a_level_kept:     assert property (vectorCall && vectorSource == S_X0 && !$past(extAEdgeSelect)
                                       && !$past(s.fltA) |-> requestFlags[F_EXTA])
        else $error("Level external flag cleared on vectoring.");
    a_onehz_kept:     assert property ($past(s.flags[F_ONEHZ]) && !$past(swFlagClear[F_ONEHZ])
                                       |-> requestFlags[F_ONEHZ])
        else $error("One-hertz flag lost without software clear.");
    a_ret_low:        assert property (instrEnd && irqReturnInstr && !s.activeHi && s.activeLo
                                       |=> !activeLow && pcRestore)
        else $error("Return did not clear active low level.");
    a_high_wins:      assert property (vectorCall && $past(|(pend & irqLevel))
                                       |-> activeHigh)
        else $error("Low request won over pending high request.");
    a_sw_set:         assert property ($past(swFlagSet[F_TMRB])
                                       |-> requestFlags[F_TMRB])
        else $error("Software set of timer flag lost.");

    c_simple_call:    cover property (vectorCall && activeLow);
    c_preempt:        cover property (activeLow && !activeHigh ##1 vectorCall && activeHigh);
    c_return:         cover property (pcRestore && !activeHigh && !activeLow);
    c_level_call:     cover property (vectorCall && vectorSource == S_X0 && requestFlags[F_EXTA]);
    c_nested_return:  cover property (pcRestore && !activeHigh && activeLow);

endmodule : two_level_nested_interrupt_unit

`default_nettype wire

// ==== tb/cpu_sequencer_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_sequencer_model
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic retReq,
    input  wire logic accReq,
    output logic      instrEnd,
    output logic      irqReturnInstr,
    output logic      enPrioAccess
);
    logic [1:0] phaseCnt;

    // Ends one instruction every four clocks, changing just after the falling edge.
    always @(negedge clk)
    begin
        if (rst || !run)
        begin
            phaseCnt <= 2'h0;
            instrEnd <= 1'b0;
        end
        else
        begin
            phaseCnt <= phaseCnt + 2'h1;
            instrEnd <= (phaseCnt == 2'h3);
        end
    end

    // Return and register access only qualify an instruction's last cycle.
    assign irqReturnInstr = instrEnd & retReq;
    assign enPrioAccess   = instrEnd & accReq;
endmodule : cpu_sequencer_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
    import irq_pkg::*;

    typedef struct packed {
        logic [16:0] setMask;
        logic [14:0] lvl;
        logic [3:0]  src;
        logic [16:0] after;
    } row_t;

    // Flags set by software, levels, winner (f for none) and flags left after the call.
    row_t rows [7] = '{
        '{17'h00004, 15'h0000, 4'h3, 17'h00000},
        '{17'h01100, 15'h0000, 4'h5, 17'h01100},
        '{17'h02100, 15'h1000, 4'hc, 17'h02100},
        '{17'h10000, 15'h0000, 4'h6, 17'h10000},
        '{17'h04801, 15'h0000, 4'h0, 17'h04800},
        '{17'h00880, 15'h4000, 4'he, 17'h00880},
        '{17'h08000, 15'h0000, 4'hf, 17'h00000}};

    logic        clk = 1'b0, rst = 1'b1, pinA_n = 1'b1, pinB_n = 1'b1, edgeA = 1'b1, edgeB = 1'b1;
    logic        globalEn = 1'b1, run = 1'b0, retReq = 1'b0, accReq = 1'b0, seen, endSeen;
    logic [3:0]  capPin = 4'h0, capRise = 4'h1, capFall = 4'h2;
    logic [16:0] strobe [3] = '{17'h0, 17'h0, 17'h0};
    logic [14:0] enable = 15'h7fff, level = 15'h0;
    logic        vectorCall, pcRestore, activeHigh, activeLow, idleWake, instrEnd, irqReturnInstr, enPrioAccess;
    logic [15:0] vectorAddr;
    logic [3:0]  vectorSource;
    logic [16:0] requestFlags;
    int          errTotal = 0, nCompared = 0, cycles = 0;

    two_level_nested_interrupt_unit #(.MACHINE_CYCLE_CLKS(2)) dut (
        .clk(clk), .rst(rst), .extIrqPinA_n(pinA_n), .extIrqPinB_n(pinB_n),
        .extAEdgeSelect(edgeA), .extBEdgeSelect(edgeB), .capturePin(capPin),
        .captureIrqRise(capRise), .captureIrqFall(capFall), .timerAOverflow(strobe[2][2]),
        .timerBOverflow(strobe[2][3]), .t2CaptureEvent(strobe[2][7:4]), .t2CompareEvent(strobe[2][10:8]),
        .t2Overflow(strobe[2][11]), .uartRxDone(strobe[2][12]), .uartTxDone(strobe[2][13]),
        .i2cEvent(strobe[2][14]), .adcScanDone(strobe[2][15]), .oneHzTick(strobe[2][16]),
        .swFlagSet(strobe[0]), .swFlagClear(strobe[1]), .globalIrqEnable(globalEn),
        .irqEnable(enable), .irqLevel(level), .instrEnd(instrEnd), .irqReturnInstr(irqReturnInstr),
        .enPrioAccess(enPrioAccess), .vectorCall(vectorCall), .vectorAddr(vectorAddr),
        .vectorSource(vectorSource), .pcRestore(pcRestore), .activeHigh(activeHigh),
        .activeLow(activeLow), .requestFlags(requestFlags), .idleWake(idleWake));

    cpu_sequencer_model cpu (.clk(clk), .rst(rst), .run(run), .retReq(retReq), .accReq(accReq),
        .instrEnd(instrEnd), .irqReturnInstr(irqReturnInstr), .enPrioAccess(enPrioAccess));

    always #2 clk = ~clk;

    task automatic report_and_stop();
        $display("TB: %0d compared, %0d mismatched", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Kind 0 sets by software, 1 clears by software, 2 is a peripheral set pulse.
    task automatic pulse(input int kind, input logic [16:0] m);
        strobe[kind] = m;
        @(negedge clk);
        strobe[kind] = 17'h0;
    endtask : pulse

    task automatic wait_for(input logic ret);
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++)
        begin
            @(negedge clk);
            seen = ret ? (pcRestore === 1'b1) : (vectorCall === 1'b1);
        end
    endtask : wait_for

    task automatic do_return();
        retReq = 1'b1;
        wait_for(1'b1);
        retReq = 1'b0;
        check(seen, 1);
    endtask : do_return

    always @(posedge clk)
    begin
        endSeen <= instrEnd;
        cycles++;
        if (cycles == 10000)
        begin
            errTotal++;
            report_and_stop();
        end
    end

    always @(negedge clk)
        if (vectorCall === 1'b1)
            check(endSeen, 1);

    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check({requestFlags, vectorCall, pcRestore, activeHigh, activeLow}, 0);
        run = 1'b1;
        foreach (rows[i])
        begin
            level = rows[i].lvl;
            pulse(0, rows[i].setMask);
            wait_for(1'b0);
            if (rows[i].src == 4'hf)
                check({seen, requestFlags}, 0);
            else
            begin
                check({seen, vectorSource, vectorAddr}, {1'b1, rows[i].src, VEC_BASE_DEF + VEC_STEP_DEF * rows[i].src});
                check({activeHigh, activeLow}, {rows[i].lvl[rows[i].src], ~rows[i].lvl[rows[i].src]});
                check(requestFlags, rows[i].after);
                pulse(1, 17'h1ffff);
                do_return();
                check({activeHigh, activeLow}, 0);
            end
        end
        $display("test table rows done");
        run = 1'b0;
        for (int b = 2; b < 17; b++)
        begin
            pulse(2, 17'h1 << b);
            check(requestFlags, (b == 15) ? 17'h08000 : (17'h1 << b));
            pulse(1, 17'h1ffff);
        end
        capPin = 4'h3;
        repeat (8) @(negedge clk);
        check(requestFlags[7:4], 4'h1);
        pulse(1, 17'h1ffff);
        capPin = 4'h0;
        repeat (8) @(negedge clk);
        check(requestFlags[7:4], 4'h2);
        enable = 15'h6fff;
        pulse(0, 17'h01100);
        check(idleWake, 0);
        enable = 15'h7fff;
        @(negedge clk);
        check(idleWake, 1);
        $display("test flag sources done");
        pulse(1, 17'h1ffff);
        globalEn = 1'b0;
        run = 1'b1;
        pulse(0, 17'h00004);
        wait_for(1'b0);
        check(seen, 0);
        pulse(1, 17'h00004);
        repeat (2) @(negedge clk);
        globalEn = 1'b1;
        wait_for(1'b0);
        check(seen, 0);
        enable = 15'h7ff7;
        pulse(0, 17'h00004);
        wait_for(1'b0);
        check(seen, 0);
        enable = 15'h7fff;
        accReq = 1'b1;
        wait_for(1'b0);
        check(seen, 0);
        accReq = 1'b0;
        wait_for(1'b0);
        check({seen, vectorSource, activeLow}, {1'b1, 4'h3, 1'b1});
        level = 15'h0002;
        pulse(0, 17'h04000);
        wait_for(1'b0);
        check({seen, vectorSource, activeHigh, activeLow, requestFlags[14]}, {1'b1, 4'h1, 3'h7});
        level = 15'h0003;
        pulse(0, 17'h00001);
        wait_for(1'b0);
        check(seen, 0);
        do_return();
        check({activeHigh, activeLow}, 2'h1);
        wait_for(1'b0);
        check({seen, vectorSource, requestFlags[0]}, {1'b1, 4'h0, 1'b0});
        pulse(1, 17'h1ffff);
        do_return();
        @(negedge clk);
        do_return();
        check({activeHigh, activeLow}, 2'h0);
        level = 15'h0;
        edgeA = 1'b0;
        pinA_n = 1'b0;
        wait_for(1'b0);
        check({seen, vectorSource, requestFlags[0]}, {1'b1, 4'h0, 1'b1});
        pinA_n = 1'b1;
        repeat (8) @(negedge clk);
        check(requestFlags[0], 0);
        do_return();
        pinB_n = 1'b0;
        wait_for(1'b0);
        check({seen, vectorSource, requestFlags[1]}, {1'b1, 4'h6, 1'b0});
        do_return();
        wait_for(1'b0);
        check(seen, 0);
        pinB_n = 1'b1;
        pulse(0, 17'h00880);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        check({requestFlags, activeHigh, activeLow, vectorCall}, 0);
        rst = 1'b0;
        $display("test handling and reset done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
